// ===== design/ssr_dev_end.sv
/*
 * Device end of the serial register access port: decodes direction,
 * address and data from the host, and turns them into register strobes
 * on its user side. Assumes a register space on the same mclk that
 * answers a read strobe with data in the same cycle.
 */
// Notes on behaviour
// - Device only answers; never starts a transfer.
// - Clock mode 00: clock idles low.
// - Sample on rising edge, change on falling.
// - Host holds select low for whole transfer.
// - 24 clocks per single byte, 8 more each.
// - First bit: 1 reads, 0 writes.
// - Next seven bits: address, MSB first.
// - 4-wire after reset; select bit picks 3-wire.
// - Write: ignored byte, then data on 17-24.
// - Burst write steps address every 8 clocks.
// - Select rising ends transfer at any point.
// - Read: data out MSB first on 17-24.
// - Burst read steps address every 8 clocks.
`timescale 1ns/1ps

module ssr_dev_end (
    input  wire logic                      mclk,       // System clock.
    input  wire logic                      resetn,     // Async reset.
    ssr_link_if.dev                        link,       // Serial pins.
    input  wire logic                      three_wire, // Mode select bit.
    output logic                           reg_we,     // Write strobe.
    output logic                           reg_re,     // Read strobe.
    output logic [ssr_pkg::ADDR_W-1:0]     reg_addr,   // Strobe address.
    output logic [ssr_pkg::DATA_W-1:0]     reg_wdata,  // Write data.
    input  wire logic [ssr_pkg::DATA_W-1:0] reg_rdata  // Read data.
);

    // ********************************************************
    // Declarations
    // ********************************************************
    logic [2:0]                  meta_reg;   // First synchroniser stage.
    logic [2:0]                  sync_reg;   // Second synchroniser stage.
    logic                        sclk_d_reg; // Previous synced clock.
    logic                        sclk_s;     // Synced serial clock.
    logic                        cs_hi;      // Synced select is high.
    logic                        sdi;        // Synced input data bit.
    logic                        rise;       // Rising clock inside frame.
    logic                        fall;       // Falling clock inside frame.
    logic [4:0]                  cnt_reg;    // Rising edges in the frame, back to 16 after each byte.
    logic                        dir_reg;    // 1 for read, 0 for write.
    logic [ssr_pkg::ADDR_W-1:0]  addr_reg;   // Working register address.
    logic [ssr_pkg::DATA_W-1:0]  rx_reg;     // Input shift register.
    logic [ssr_pkg::DATA_W-1:0]  tx_reg;     // Output shift register.
    logic                        dout_reg;   // Bit on the output lines.
    logic                        miso_oe_reg; // Drives the output line.
    logic                        sdio_oe_reg; // Drives the shared line.
    logic                        we_reg;     // Write strobe register.
    logic                        re_reg;     // Read strobe register.
    logic [ssr_pkg::ADDR_W-1:0]  raddr_reg;  // Address of the strobe.
    logic [ssr_pkg::DATA_W-1:0]  wdata_reg;  // Data of the write strobe.
    logic [ssr_pkg::DATA_W-1:0]  rx_next;    // Byte after this edge.

    // ********************************************************
    // Pin synchronisers
    // ********************************************************

    // Each pin passes two flip-flops before any logic looks at it.
    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= (i == 0) ? link.sclk :
                                   (i == 1) ? link.cs_n : link.data_line;
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign sclk_s = sync_reg[0];
    assign cs_hi  = sync_reg[1];
    assign sdi    = sync_reg[2];

    // Remembers the synced clock to find its edges.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
        end
    end

    // Edges count only while the host holds select low, so the device
    // never acts on its own; the clock is taken to idle low.
    assign rise = sclk_s & ~sclk_d_reg & ~cs_hi;
    assign fall = ~sclk_s & sclk_d_reg & ~cs_hi;

    // The byte completed by the current rising edge.
    assign rx_next = {rx_reg[ssr_pkg::DATA_W-2:0], sdi};

    // ********************************************************
    // Frame decode
    // ********************************************************

    // Counts edges, latches direction and address, and steps the address
    // after each data byte; select high drops any partial byte.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg  <= 5'h00;
            dir_reg  <= 1'b0;
            addr_reg <= '0;
            rx_reg   <= ssr_pkg::DATA_RESET;
        end else if (cs_hi) begin
            // Next frame starts again with the direction bit.
            cnt_reg <= 5'h00;
            rx_reg  <= ssr_pkg::DATA_RESET;
        end else if (rise) begin
            rx_reg <= rx_next;
            if (cnt_reg == ssr_pkg::CNT_BYTE_LAST) begin
                // Each data byte is eight more clocks after the header.
                cnt_reg  <= ssr_pkg::CNT_HDR;
                addr_reg <= addr_reg + 7'h01;
            end else begin
                cnt_reg <= cnt_reg + 5'h01;
            end
            if (cnt_reg == ssr_pkg::CNT_DIR_LAST) begin
                dir_reg <= sdi;
            end
            if (cnt_reg == ssr_pkg::CNT_ADDR_LAST) begin
                addr_reg <= rx_next[ssr_pkg::ADDR_W-1:0];
            end
        end
    end

    // ********************************************************
    // Register strobes
    // ********************************************************

    // Issues one-cycle strobes: a read at the end of the header and after
    // each read byte, a write after each received data byte. The second
    // byte of a write is never stored.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            we_reg    <= 1'b0;
            re_reg    <= 1'b0;
            raddr_reg <= '0;
            wdata_reg <= ssr_pkg::DATA_RESET;
        end else begin
            we_reg <= 1'b0;
            re_reg <= 1'b0;
            if (rise && cnt_reg == ssr_pkg::CNT_HDR_LAST && dir_reg) begin
                re_reg    <= 1'b1;
                raddr_reg <= addr_reg;
            end else if (rise && cnt_reg == ssr_pkg::CNT_BYTE_LAST) begin
                if (dir_reg) begin
                    // Fetch the next register for the following byte.
                    re_reg    <= 1'b1;
                    raddr_reg <= addr_reg + 7'h01;
                end else begin
                    // Data of clocks 17 to 24 goes to the current address.
                    we_reg    <= 1'b1;
                    raddr_reg <= addr_reg;
                    wdata_reg <= rx_next;
                end
            end
        end
    end

    // ********************************************************
    // Read data output
    // ********************************************************

    // Loads fetched data and shifts it out MSB first on falling edges
    // after the header; the line in use follows the mode select bit,
    // which the register space holds at 4-wire out of reset.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_reg      <= ssr_pkg::DATA_RESET;
            dout_reg    <= 1'b0;
            miso_oe_reg <= 1'b0;
            sdio_oe_reg <= 1'b0;
        end else if (cs_hi) begin
            // Outside a frame both lines are released.
            miso_oe_reg <= 1'b0;
            sdio_oe_reg <= 1'b0;
        end else if (re_reg) begin
            tx_reg <= reg_rdata;
        end else if (fall && dir_reg && cnt_reg >= ssr_pkg::CNT_HDR) begin
            dout_reg    <= tx_reg[ssr_pkg::DATA_W-1];
            tx_reg      <= {tx_reg[ssr_pkg::DATA_W-2:0], 1'b0};
            miso_oe_reg <= ~three_wire;
            sdio_oe_reg <= three_wire;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign link.dev_dout    = dout_reg;
    assign link.dev_miso_oe = miso_oe_reg;
    assign link.dev_sdio_oe = sdio_oe_reg;
    assign reg_we           = we_reg;
    assign reg_re           = re_reg;
    assign reg_addr         = raddr_reg;
    assign reg_wdata        = wdata_reg;

endmodule : ssr_dev_end

// ===== design/ssr_host_end.sv
/*
 * Host end of the serial register access port: runs one read or write
 * transfer, single or burst, when started from its user side, making
 * the serial clock by dividing mclk. Assumes the user holds start
 * fields stable for the cycle of start and supplies write bytes on time.
 */
`timescale 1ns/1ps

module ssr_host_end (
    input  wire logic                       mclk,       // System clock.
    input  wire logic                       resetn,     // Async reset.
    ssr_link_if.host                        link,       // Serial pins.
    input  wire logic                       three_wire, // Shared line mode.
    input  wire logic                       start,      // Begin transfer.
    input  wire logic                       rw,         // 1 read, 0 write.
    input  wire logic [ssr_pkg::ADDR_W-1:0] addr,       // First address.
    input  wire logic [7:0]                 len,        // Data bytes.
    input  wire logic [ssr_pkg::DATA_W-1:0] wr_data,    // Next write byte.
    output logic                            wr_take,    // wr_data taken.
    output logic [ssr_pkg::DATA_W-1:0]      rd_data,    // Read byte.
    output logic                            rd_valid,   // rd_data new.
    output logic                            busy        // Transfer active.
);

    // ********************************************************
    // Declarations
    // ********************************************************
    typedef enum logic [1:0] {
        SSR_IDLE = 2'b00,       // Select high, waiting for start.
        SSR_RUN  = 2'b01,       // Clocking bits.
        SSR_END  = 2'b10        // Last low half before select rises.
    } ssr_state_type;

    ssr_state_type               state_reg;  // Transfer state.
    logic [3:0]                  div_reg;    // Half period divider.
    logic                        tick;       // One-cycle half period pulse.
    logic [11:0]                 bcnt_reg;   // Rising edges made.
    logic [11:0]                 total_reg;  // Rising edges wanted.
    logic                        rw_reg;     // Direction of the transfer.
    logic [ssr_pkg::DATA_W-1:0]  tx_reg;     // Bits still to send.
    logic [ssr_pkg::DATA_W-1:0]  rx_reg;     // Bits received.
    logic                        sclk_reg;   // Serial clock.
    logic                        cs_n_reg;   // Chip select, active low.
    logic                        dout_reg;   // Data line value.
    logic                        doe_reg;    // Drives the data line.
    logic                        take_reg;   // Write byte taken pulse.
    logic [ssr_pkg::DATA_W-1:0]  rdat_reg;   // Last read byte.
    logic                        rval_reg;   // Read byte pulse.
    logic                        busy_reg;   // Transfer active.
    logic                        sin_meta_reg; // First input stage.
    logic                        sin_reg;    // Synced input bit.

    // ********************************************************
    // Clock divider and input synchroniser
    // ********************************************************

    // Gives one tick per half serial clock period while busy.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= 4'h0;
        end else if (state_reg == SSR_IDLE || tick) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    assign tick = (div_reg == ssr_pkg::SCLK_HALF_CYC - 4'h1);

    // Read data comes on the shared line in 3-wire mode.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sin_meta_reg <= 1'b0;
            sin_reg      <= 1'b0;
        end else begin
            sin_meta_reg <= three_wire ? link.data_line : link.miso_line;
            sin_reg      <= sin_meta_reg;
        end
    end

    // ********************************************************
    // Transfer sequencer
    // ********************************************************

    // Drives select, clock and data; new bits go out on falling edges.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= SSR_IDLE;
            bcnt_reg  <= 12'h000;
            total_reg <= 12'h000;
            rw_reg    <= 1'b0;
            tx_reg    <= ssr_pkg::DATA_RESET;
            sclk_reg  <= 1'b0;
            cs_n_reg  <= 1'b1;
            dout_reg  <= 1'b0;
            doe_reg   <= 1'b0;
            take_reg  <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            take_reg <= 1'b0;
            case (state_reg)
                SSR_IDLE: begin
                    if (start) begin
                        // Select falls with the direction bit set up.
                        cs_n_reg  <= 1'b0;
                        doe_reg   <= 1'b1;
                        dout_reg  <= rw;
                        tx_reg    <= {addr, 1'b0};
                        rw_reg    <= rw;
                        bcnt_reg  <= 12'h000;
                        total_reg <= ssr_pkg::HOST_HDR_BITS +
                                     {1'b0, len, 3'b000};
                        busy_reg  <= 1'b1;
                        state_reg <= SSR_RUN;
                    end
                end
                SSR_RUN: begin
                    if (tick && !sclk_reg) begin
                        sclk_reg <= 1'b1;
                        bcnt_reg <= bcnt_reg + 12'h001;
                    end else if (tick) begin
                        sclk_reg <= 1'b0;
                        if (bcnt_reg == total_reg) begin
                            state_reg <= SSR_END;
                        end else if (bcnt_reg[2:0] != 3'b000) begin
                            dout_reg <= tx_reg[ssr_pkg::DATA_W-1];
                            tx_reg   <= {tx_reg[ssr_pkg::DATA_W-2:0], 1'b0};
                        end else if (bcnt_reg == ssr_pkg::HOST_ADDR_BITS) begin
                            // The second byte is a don't-care.
                            dout_reg <= 1'b0;
                            tx_reg   <= ssr_pkg::DATA_RESET;
                        end else begin
                            // A data byte starts: writes take user data.
                            dout_reg <= rw_reg ? 1'b0 : wr_data[7];
                            tx_reg   <= {wr_data[6:0], 1'b0};
                            take_reg <= ~rw_reg;
                            doe_reg  <= ~(rw_reg & three_wire);
                        end
                    end
                end
                SSR_END: begin
                    if (tick) begin
                        cs_n_reg  <= 1'b1;
                        doe_reg   <= 1'b0;
                        busy_reg  <= 1'b0;
                        state_reg <= SSR_IDLE;
                    end
                end
                default: begin
                    state_reg <= SSR_IDLE;
                end
            endcase
        end
    end

    // Samples on rising edges and hands up each read data byte.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_reg   <= ssr_pkg::DATA_RESET;
            rdat_reg <= ssr_pkg::DATA_RESET;
            rval_reg <= 1'b0;
        end else begin
            rval_reg <= 1'b0;
            if (state_reg == SSR_RUN && tick && !sclk_reg) begin
                rx_reg <= {rx_reg[ssr_pkg::DATA_W-2:0], sin_reg};
                if (rw_reg && bcnt_reg >= ssr_pkg::HOST_HDR_BITS &&
                    bcnt_reg[2:0] == 3'b111) begin
                    rdat_reg <= {rx_reg[ssr_pkg::DATA_W-2:0], sin_reg};
                    rval_reg <= 1'b1;
                end
            end
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign link.sclk      = sclk_reg;
    assign link.cs_n      = cs_n_reg;
    assign link.host_dout = dout_reg;
    assign link.host_doe  = doe_reg;
    assign wr_take        = take_reg;
    assign rd_data        = rdat_reg;
    assign rd_valid       = rval_reg;
    assign busy           = busy_reg;

endmodule : ssr_host_end

// ===== design/ssr_link_if.sv
/*
 * Pin-level link between the host end and the device end of the serial
 * register access port. Assumes the bench instances it twice, joining both
 * ends on link and a device end alone on link2; line levels are resolved here from the output enables.
 */
`timescale 1ns/1ps

interface ssr_link_if;

    // ********************************************************
    // Pins and drivers
    // ********************************************************
    logic sclk;          // Serial clock, driven by the host.
    logic cs_n;          // Chip select, active low, driven by the host.
    logic host_dout;     // Host value for the data line.
    logic host_doe;      // Host drives the data line.
    logic dev_dout;      // Device value for its output lines.
    logic dev_miso_oe;   // Device drives the separate output line.
    logic dev_sdio_oe;   // Device drives the shared data line.
    logic data_line;     // Resolved level of the data line.
    logic miso_line;     // Resolved level of the device output line.

    // The data line carries host data, or device data in 3-wire reads.
    assign data_line = host_doe    ? host_dout :
                       dev_sdio_oe ? dev_dout  : ssr_pkg::LINE_IDLE;

    // The output line floats to the idle level unless the device drives it.
    assign miso_line = dev_miso_oe ? dev_dout : ssr_pkg::LINE_IDLE;

    // ********************************************************
    // Views of the two parties
    // ********************************************************
    modport host (output sclk, output cs_n, output host_dout,
                  output host_doe, input data_line, input miso_line);
    modport dev  (input sclk, input cs_n, input data_line,
                  output dev_dout, output dev_miso_oe, output dev_sdio_oe);

endinterface : ssr_link_if

// ===== design/ssr_pkg.sv
/*
 * Shared constants for the serial register access port: field widths,
 * bit-count landmarks of a transfer and the host clock divider timing.
 * Assumes both ends run on mclk at 125 MHz.
 */
package ssr_pkg;

    // ********************************************************
    // Field widths
    // ********************************************************
    localparam int ADDR_W = 7;                  // Register address width.
    localparam int DATA_W = 8;                  // Register data width.

    // ********************************************************
    // Bit-count landmarks, counted in rising serial clock edges
    // ********************************************************
    localparam logic [4:0] CNT_DIR_LAST  = 5'h00; // Edge 1 holds the direction.
    localparam logic [4:0] CNT_ADDR_LAST = 5'h07; // Edge 8 ends the address.
    localparam logic [4:0] CNT_HDR_LAST  = 5'h0F; // Edge 16 ends the header.
    localparam logic [4:0] CNT_HDR       = 5'h10; // Count after the header.
    localparam logic [4:0] CNT_BYTE_LAST = 5'h17; // Edge 24 ends a data byte.

    // Host side counts are wider so that long bursts fit.
    localparam logic [11:0] HOST_HDR_BITS  = 12'h010; // Header length.
    localparam logic [11:0] HOST_ADDR_BITS = 12'h008; // First header byte.

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] DATA_RESET = 8'h00;  // Data registers at reset.
    localparam logic       LINE_IDLE  = 1'b1;   // Undriven line level.

    // ********************************************************
    // Host serial clock timing
    // ********************************************************
    localparam int MCLK_PERIOD_NS = 8;          // System clock period.
    localparam int SCLK_HALF_NS   = 64;         // Host serial clock half period.
    localparam logic [3:0] SCLK_HALF_CYC =
        4'(SCLK_HALF_NS / MCLK_PERIOD_NS);      // Half period in mclk cycles.

endpackage : ssr_pkg

// ===== tb/ssr_link_checker.sv
/* Pin checks for the serial link between host end and device end.
   Assumes the bench wires it to the interface signals by name. */
`timescale 1ns/1ps
module ssr_link_checker (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic host_dout,
    input wire logic data_line,
    input wire logic dev_dout,
    input wire logic dev_miso_oe,
    input wire logic dev_sdio_oe
);
    logic [11:0] rises_reg; // Rising clock edges in this frame.
    logic        rd_reg;    // Direction bit of this frame.
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Counts edges of a frame; cleared as select falls and kept after the
    // frame, since the device releases its lines a few cycles late.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) rises_reg <= 12'h000;
        else if ($fell(cs_n)) rises_reg <= 12'h000;
        else if ($rose(sclk)) rises_reg <= rises_reg + 12'h001;
    end
    // Keeps the first bit of the frame as the direction.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) rd_reg <= 1'b0;
        else if ($rose(sclk) && rises_reg == 12'h000) rd_reg <= data_line;
    end
    a_clk_idle_low: assert property (cs_n |-> !sclk)
        else $error("Clock not low while deselected.");
    a_clk_in_frame: assert property ($changed(sclk) |-> !cs_n)
        else $error("Clock moved outside a frame.");
    a_host_on_fall: assert property (!cs_n && $past(!cs_n) &&
        $changed(host_dout) |-> $fell(sclk))
        else $error("Host data moved off the falling edge.");
    a_dev_on_fall: assert property (dev_miso_oe && $past(dev_miso_oe) &&
        $changed(dev_dout) |-> $past(sclk, 4) || $past(sclk, 5))
        else $error("Device data moved off the falling edge.");
    a_out_read_only: assert property (dev_miso_oe || dev_sdio_oe |->
        rd_reg && rises_reg >= 12'h010)
        else $error("Device drove outside read data.");
    a_frame_length: assert property ($rose(cs_n) |->
        rises_reg[2:0] == 3'h0 && rises_reg >= 12'h010)
        else $error("Frame length not header plus whole bytes.");
    a_release_idle: assert property (cs_n && $past(cs_n, 5) |->
        !dev_miso_oe && !dev_sdio_oe)
        else $error("Device still drives after deselect.");
    a_one_out_mode: assert property (!(dev_miso_oe && dev_sdio_oe))
        else $error("Device drove both output lines.");
    c_write: cover property ($rose(cs_n) && !rd_reg);
    c_burst: cover property (dev_miso_oe && rises_reg > 12'h020);
    c_shared: cover property (dev_sdio_oe);
endmodule : ssr_link_checker

// ===== tb/tb_spi_slave_register_access.sv
/* Bench: host end and device end on one link, a bit-banged second link.
   Assumes package, interface and both ends are compiled first. */
`timescale 1ns/1ps
module tb_spi_slave_register_access;
    logic mclk = 0, resetn = 0, three_wire = 0, start = 0, rw = 0;
    logic [6:0] addr = 0, ra, ra2, la2;
    logic [7:0] len = 0, wr_data = 0, rd_data, wd, wd2, ld2;
    logic wr_take, rd_valid, busy, we, we2, re;
    logic [7:0] mem [128], shadow [128], wq [$], rq [$];
    int miscompares = 0, n_checks = 0, n_we2 = 0, n_re = 0, i;
    ssr_link_if link();
    ssr_link_if link2();
    always #4 mclk = ~mclk;
    ssr_host_end ssr_host_end_i (.mclk(mclk), .resetn(resetn),
        .link(link.host), .three_wire(three_wire), .start(start), .rw(rw),
        .addr(addr), .len(len), .wr_data(wr_data), .wr_take(wr_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy));
    ssr_dev_end ssr_dev_end_i (.mclk(mclk), .resetn(resetn),
        .link(link.dev), .three_wire(three_wire), .reg_we(we), .reg_re(re),
        .reg_addr(ra), .reg_wdata(wd), .reg_rdata(mem[ra]));
    ssr_dev_end ssr_dev_end_i2 (.mclk(mclk), .resetn(resetn),
        .link(link2.dev), .three_wire(1'b0), .reg_we(we2), .reg_re(),
        .reg_addr(ra2), .reg_wdata(wd2), .reg_rdata(8'h00));
    ssr_link_checker ssr_link_checker_i (.mclk(mclk), .resetn(resetn),
        .sclk(link.sclk), .cs_n(link.cs_n), .host_dout(link.host_dout),
        .data_line(link.data_line), .dev_dout(link.dev_dout),
        .dev_miso_oe(link.dev_miso_oe), .dev_sdio_oe(link.dev_sdio_oe));
    // Register space, read data, write feed and second-link capture.
    always @(posedge mclk) if (we === 1'b1) mem[ra] <= wd;
    always @(negedge mclk) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
        if (re === 1'b1) n_re++;
        if (wr_take === 1'b1) void'(wq.pop_front());
        if (wq.size() > 0) wr_data = wq[0];
        if (we2 === 1'b1) begin
            n_we2++; la2 = ra2; ld2 = wd2;
        end
    end
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // One host transfer of n bytes from address a, then its checks.
    task xfer(input logic r, input logic [6:0] a, input int n);
        int k;
        wq.delete(); rq.delete(); n_re = 0;
        for (k = 0; k < n; k++) begin
            wq.push_back(8'($urandom));
            if (!r) shadow[7'(a + k)] = wq[k];
        end
        if (n > 0) wr_data = wq[0];
        rw = r; addr = a; len = 8'(n); start = 1;
        @(negedge mclk) start = 0;
        for (k = 0; k < 9000 && busy !== 1'b0; k++) @(negedge mclk);
        if (k == 9000) begin miscompares++; tally_and_finish; end
        repeat (8) @(negedge mclk);
        chk8(8'(rq.size()), r ? 8'(n) : 8'h00);
        chk8(8'(n_re), r ? 8'(n + 1) : 8'h00);
        for (k = 0; k < n; k++)
            if (r) chk8(rq[k], shadow[7'(a + k)]);
            else chk8(mem[7'(a + k)], shadow[7'(a + k)]);
    endtask : xfer
    // Bit-bangs n bits of v on the second link, 64 ns clock.
    task bang(input logic [23:0] v, input int n);
        link2.cs_n = 0;
        for (i = n - 1; i >= 0; i--) begin
            link2.host_dout = v[i];
            repeat (4) @(negedge mclk) link2.sclk = 1;
            repeat (4) @(negedge mclk) link2.sclk = 0;
        end
        repeat (4) @(negedge mclk) link2.cs_n = 1;
        repeat (8) @(negedge mclk);
    endtask : bang
    initial begin
        link2.sclk = 0; link2.cs_n = 1; link2.host_doe = 1;
        link2.host_dout = 0;
        void'($urandom(32'h0DE5));
        for (i = 0; i < 128; i++) begin
            mem[i] = 8'($urandom); shadow[i] = mem[i];
        end
        repeat (20) @(negedge mclk);
        resetn = 1;
        for (int m = 0; m < 2; m++) begin
            three_wire = m[0];
            xfer(0, 7'h7E, 3); xfer(1, 7'h7E, 3); xfer(1, 7'h7F, 1);
            xfer(0, 7'h10, 0);
            repeat (5) begin
                addr = 7'($urandom); len = 8'($urandom_range(1, 4));
                xfer(0, addr, len); xfer(1, addr, len);
            end
        end
        bang(24'h01100F, 20); bang(24'h2AFFC3, 24);
        chk8(8'(n_we2), 8'h01);
        chk8({1'b0, la2}, 8'h2A);
        chk8(ld2, 8'hC3);
        tally_and_finish;
    end
endmodule : tb_spi_slave_register_access
